// ==== verilog/bcp_operand_regs.sv ====
// operand register bank: source position / line errors, expansion colours, pattern bitmap
//
// Overview of operation
// - in vector mode the upper half is the signed axial error of a line.
// - in block-transfer mode the signed low half is the source row coordinate.
// - in vector mode the signed low half is the diagonal error of a line.
// - at 16 bpp the whole colour register is one RGB pixel colour.
// - source bit 0 expands to the first source colour.
// - source bit 1 expands to the second source colour.
// - pattern expansion colours come from the four pattern colour registers, except direct colour patterns, which take them from the bitmap.
// - the first pattern word is bits 31..0 of the pattern bitmap.
// - the second pattern word is bits 63..32 of the pattern bitmap.
// - pattern format selects solid, monochrome, dither or direct colour pattern.
`timescale 1ns/1ps
`default_nettype none
`include "bcp_regs.svh"

module bcp_operand_regs (
    input  wire logic                 clk_sys,
    input  wire logic                 nrst,
    input  wire logic                 bus_sel,
    input  wire logic                 bus_wr,
    input  wire logic                 bus_rd,
    input  wire logic [15:0]          bus_addr,
    input  wire logic [3:0]           bus_be,
    input  wire logic [31:0]          bus_wdata,
    output logic [31:0]               bus_rdata,
    output logic                      bus_ack,
    input  wire logic                 vector_mode,
    input  wire logic                 bpp8,
    input  wire bcp_pkg::bcp_pat_fmt_e pattern_format_select,
    input  wire logic                 pix_req,
    input  wire logic [2:0]           pix_x,
    input  wire logic [2:0]           pix_y,
    input  wire logic                 src_bit,
    output logic [15:0]               source_row_coordinate,
    output logic [15:0]               source_column_coordinate,
    output logic [15:0]               line_axial_error_term,
    output logic [15:0]               line_diagonal_error_term,
    output logic                      pix_valid,
    output logic [15:0]               src_pix_color,
    output logic [15:0]               pat_pix_color,
    output logic                      pat_pix_bit
);
    import bcp_pkg::*;

    bcp_state_s state_reg;
    bcp_state_s state_next;

    bcp_sel_if sel_bus ();

    // merge a write into a word under its byte enables
    function automatic logic [31:0] merge_word(input logic [31:0] old_w,
                                               input logic [31:0] new_w,
                                               input logic [3:0]  be);
        logic [31:0] res;
        res = old_w;
        for (int i = 0; i < 4; i++) begin
            if (be[i])
                res[i*8 +: 8] = new_w[i*8 +: 8];
        end
        merge_word = res;
    endfunction : merge_word

    // word-aligned decode of the byte offset; low two bits pick lanes via enables
    function automatic logic hit(input logic [15:0] addr, input logic [15:0] ofs);
        hit = (addr[15:2] == ofs[15:2]);
    endfunction : hit

    // pair two 16-bit colour registers into one bus word, odd halfword on top
    function automatic logic [31:0] pair(input bcp_color_t lo, input bcp_color_t hi);
        pair = {hi, lo};
    endfunction : pair

    logic        wr_en;
    logic        rd_en;
    logic [31:0] cur_word;
    logic [31:0] new_word;

    // bank contents drive the selector directly; its answers are registered below
    assign sel_bus.src_color_zero = state_reg.src_color_zero;
    assign sel_bus.src_color_one  = state_reg.src_color_one;
    assign sel_bus.pat_color[0]   = state_reg.pat_color_zero;
    assign sel_bus.pat_color[1]   = state_reg.pat_color_one;
    assign sel_bus.pat_color[2]   = state_reg.pat_color_two;
    assign sel_bus.pat_color[3]   = state_reg.pat_color_three;
    assign sel_bus.pat_bits       = state_reg.pat_bits;
    assign sel_bus.pat_fmt        = pattern_format_select;
    assign sel_bus.bpp8           = bpp8;
    assign sel_bus.pix_x          = pix_x;
    assign sel_bus.pix_y          = pix_y;
    assign sel_bus.src_bit        = src_bit;

    bcp_color_select u_color_select (
        .sel (sel_bus.sel)
    );

    // access strobes; a select without a strobe does nothing
    assign wr_en = bus_sel & bus_wr;
    assign rd_en = bus_sel & bus_rd & ~bus_wr;

    // current word at the addressed offset; unmapped offsets read zero
    always_comb begin
        cur_word = 32'h0000_0000;
        if (hit(bus_addr, `BCP_OFS_SRC_POS))
            cur_word = state_reg.src_pos;
        else if (hit(bus_addr, `BCP_OFS_SRC_COLOR))
            cur_word = pair(state_reg.src_color_zero, state_reg.src_color_one);
        else if (hit(bus_addr, `BCP_OFS_PAT_COLOR_01))
            cur_word = pair(state_reg.pat_color_zero, state_reg.pat_color_one);
        else if (hit(bus_addr, `BCP_OFS_PAT_COLOR_23))
            cur_word = pair(state_reg.pat_color_two, state_reg.pat_color_three);
        else if (hit(bus_addr, `BCP_OFS_PAT_WORD_0))
            cur_word = state_reg.pat_bits[31:0];
        else if (hit(bus_addr, `BCP_OFS_PAT_WORD_1))
            cur_word = state_reg.pat_bits[63:32];
    end

    assign new_word = merge_word(cur_word, bus_wdata, bus_be);

    // next state: register writes, read answer, decoded fields, pixel colours
    always_comb begin
        state_next     = state_reg;
        state_next.ack = wr_en | rd_en;
        if (rd_en)
            state_next.rdata = cur_word;

        // writes; the colour bytes are stored as given, the selector copies the low byte at 8 bpp
        if (wr_en) begin
            if (hit(bus_addr, `BCP_OFS_SRC_POS)) begin
                state_next.src_pos = new_word;
            end else if (hit(bus_addr, `BCP_OFS_SRC_COLOR)) begin
                state_next.src_color_zero = new_word[`BCP_HALF_LO_MSB:`BCP_HALF_LO_LSB];
                state_next.src_color_one  = new_word[`BCP_HALF_HI_MSB:`BCP_HALF_HI_LSB];
            end else if (hit(bus_addr, `BCP_OFS_PAT_COLOR_01)) begin
                state_next.pat_color_zero = new_word[`BCP_HALF_LO_MSB:`BCP_HALF_LO_LSB];
                state_next.pat_color_one  = new_word[`BCP_HALF_HI_MSB:`BCP_HALF_HI_LSB];
            end else if (hit(bus_addr, `BCP_OFS_PAT_COLOR_23)) begin
                state_next.pat_color_two   = new_word[`BCP_HALF_LO_MSB:`BCP_HALF_LO_LSB];
                state_next.pat_color_three = new_word[`BCP_HALF_HI_MSB:`BCP_HALF_HI_LSB];
            end else if (hit(bus_addr, `BCP_OFS_PAT_WORD_0)) begin
                state_next.pat_bits[31:0] = new_word;
            end else if (hit(bus_addr, `BCP_OFS_PAT_WORD_1)) begin
                state_next.pat_bits[63:`BCP_PAT_WORD_1_LSB] = new_word;
            end
        end

        // field split by mode; the field that does not apply to the mode reads zero
        // so a consumer cannot pick up a stale coordinate as an error term
        if (vector_mode) begin
            state_next.axial_err = state_reg.src_pos[`BCP_HALF_HI_MSB:`BCP_HALF_HI_LSB];
            state_next.diag_err  = state_reg.src_pos[`BCP_HALF_LO_MSB:`BCP_HALF_LO_LSB];
            state_next.row_coord = 16'h0000;
            state_next.col_coord = 16'h0000;
        end else begin
            state_next.row_coord = state_reg.src_pos[`BCP_HALF_LO_MSB:`BCP_HALF_LO_LSB];
            state_next.col_coord = state_reg.src_pos[`BCP_HALF_HI_MSB:`BCP_HALF_HI_LSB];
            state_next.axial_err = 16'h0000;
            state_next.diag_err  = 16'h0000;
        end

        // pixel answer one clock after the request; colours hold until the next one
        state_next.pix_valid = pix_req;
        if (pix_req) begin
            state_next.src_pix_color = sel_bus.src_color;
            state_next.pat_pix_color = sel_bus.pat_color_out;
            state_next.pat_pix_bit   = sel_bus.pat_bit;
        end
    end

    // single state register; everything resets to zero
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_reg                 <= '0;
            state_reg.src_pos         <= `BCP_RST_WORD;
            state_reg.src_color_zero  <= `BCP_RST_COLOR;
            state_reg.src_color_one   <= `BCP_RST_COLOR;
            state_reg.pat_color_zero  <= `BCP_RST_COLOR;
            state_reg.pat_color_one   <= `BCP_RST_COLOR;
            state_reg.pat_color_two   <= `BCP_RST_COLOR;
            state_reg.pat_color_three <= `BCP_RST_COLOR;
            state_reg.pat_bits        <= `BCP_RST_PAT;
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs straight from the state register
    assign bus_rdata                = state_reg.rdata;
    assign bus_ack                  = state_reg.ack;
    assign source_row_coordinate    = state_reg.row_coord;
    assign source_column_coordinate = state_reg.col_coord;
    assign line_axial_error_term    = state_reg.axial_err;
    assign line_diagonal_error_term = state_reg.diag_err;
    assign pix_valid                = state_reg.pix_valid;
    assign src_pix_color            = state_reg.src_pix_color;
    assign pat_pix_color            = state_reg.pat_pix_color;
    assign pat_pix_bit              = state_reg.pat_pix_bit;

endmodule : bcp_operand_regs

`default_nettype wire

// ==== include/bcp_regs.svh ====
// offsets, field positions, reset values and timing counts of the operand register bank
`ifndef BCP_REGS_SVH
`define BCP_REGS_SVH

// byte offsets above the block base address, one aligned 32-bit word each
`define BCP_OFS_SRC_POS      16'h8108
`define BCP_OFS_SRC_COLOR    16'h810C
`define BCP_OFS_PAT_COLOR_01 16'h8110
`define BCP_OFS_PAT_COLOR_23 16'h8114
`define BCP_OFS_PAT_WORD_0   16'h8120
`define BCP_OFS_PAT_WORD_1   16'h8124

// halfword offsets of the 16-bit colour registers inside their words
`define BCP_OFS_SRC_COLOR_1  16'h810E
`define BCP_OFS_PAT_COLOR_1  16'h8112
`define BCP_OFS_PAT_COLOR_3  16'h8116

// field positions
`define BCP_HALF_LO_MSB      15
`define BCP_HALF_LO_LSB      0
`define BCP_HALF_HI_MSB      31
`define BCP_HALF_HI_LSB      16
`define BCP_BYTE_LO_MSB      7
`define BCP_PAT_WORD_1_LSB   32

// reset values
`define BCP_RST_WORD         32'h0000_0000
`define BCP_RST_COLOR        16'h0000
`define BCP_RST_PAT          64'h0000_0000_0000_0000

// register read answer latency in clocks
`define BCP_READ_LATENCY     1

`endif

// ==== include/bcp_pkg.sv ====
// types shared by the operand register bank and its colour selector
package bcp_pkg;

    // pattern format codes, in the order of their two-bit encoding
    typedef enum logic [1:0] {
        BCP_PAT_SOLID,
        BCP_PAT_MONO,
        BCP_PAT_DITHER,
        BCP_PAT_COLOR
    } bcp_pat_fmt_e;

    typedef logic [15:0] bcp_color_t;

    // the whole state of the register bank
    typedef struct packed {
        logic [31:0] src_pos;
        bcp_color_t  src_color_zero;
        bcp_color_t  src_color_one;
        bcp_color_t  pat_color_zero;
        bcp_color_t  pat_color_one;
        bcp_color_t  pat_color_two;
        bcp_color_t  pat_color_three;
        logic [63:0] pat_bits;
        logic [31:0] rdata;
        logic        ack;
        logic [15:0] row_coord;
        logic [15:0] col_coord;
        logic [15:0] axial_err;
        logic [15:0] diag_err;
        logic        pix_valid;
        bcp_color_t  src_pix_color;
        bcp_color_t  pat_pix_color;
        logic        pat_pix_bit;
    } bcp_state_s;

endpackage : bcp_pkg

// ==== include/bcp_sel_if.sv ====
// interface between the register bank and the colour selector
`timescale 1ns/1ps
`default_nettype none

interface bcp_sel_if;
    import bcp_pkg::*;

    bcp_color_t   src_color_zero;
    bcp_color_t   src_color_one;
    bcp_color_t   pat_color [4];
    logic [63:0]  pat_bits;
    bcp_pat_fmt_e pat_fmt;
    logic         bpp8;
    logic [2:0]   pix_x;
    logic [2:0]   pix_y;
    logic         src_bit;
    bcp_color_t   src_color;
    bcp_color_t   pat_color_out;
    logic         pat_bit;

    modport bank (
        output src_color_zero, src_color_one, pat_color, pat_bits, pat_fmt, bpp8,
        output pix_x, pix_y, src_bit,
        input  src_color, pat_color_out, pat_bit
    );
    modport sel (
        input  src_color_zero, src_color_one, pat_color, pat_bits, pat_fmt, bpp8,
        input  pix_x, pix_y, src_bit,
        output src_color, pat_color_out, pat_bit
    );
endinterface : bcp_sel_if

`default_nettype wire

// ==== verilog/bcp_color_select.sv ====
// colour selector: picks source and pattern colours for one pixel
`timescale 1ns/1ps
`default_nettype none

module bcp_color_select (
    bcp_sel_if.sel sel
);
    import bcp_pkg::*;

    // at 8 bpp only the low byte is trusted; the high byte is a copy
    function automatic bcp_color_t fit_depth(input bcp_color_t c, input logic bpp8);
        fit_depth = bpp8 ? {c[7:0], c[7:0]} : c;
    endfunction : fit_depth

    logic [5:0] bit_idx;
    logic       chk_phase;
    logic [1:0] dith_idx;
    bcp_color_t direct;

    // monochrome source expansion
    always_comb begin
        if (sel.src_bit)
            sel.src_color = fit_depth(sel.src_color_one, sel.bpp8);
        else
            sel.src_color = fit_depth(sel.src_color_zero, sel.bpp8);
    end

    // pattern expansion by format; the bitmap is 8x8, row-major from bit 0
    always_comb begin
        bit_idx     = {sel.pix_y, sel.pix_x};
        sel.pat_bit = sel.pat_bits[bit_idx];
        // checkerboard phase picks between the two colours of a dither pair
        chk_phase   = sel.pix_x[0] ^ sel.pix_y[0];
        dith_idx    = {sel.pat_bit, chk_phase};
        // colour patterns: one byte per pixel at 8 bpp, one halfword at 16 bpp
        if (sel.bpp8)
            direct = {sel.pat_bits[{sel.pix_x, 3'h0} +: 8], sel.pat_bits[{sel.pix_x, 3'h0} +: 8]};
        else
            direct = sel.pat_bits[{sel.pix_x[1:0], 4'h0} +: 16];
        case (sel.pat_fmt)
            BCP_PAT_SOLID:  sel.pat_color_out = fit_depth(sel.pat_color[0], sel.bpp8);
            BCP_PAT_MONO:   sel.pat_color_out = fit_depth(sel.pat_color[{1'b0, sel.pat_bit}],
                                                          sel.bpp8);
            BCP_PAT_DITHER: sel.pat_color_out = fit_depth(sel.pat_color[dith_idx], sel.bpp8);
            BCP_PAT_COLOR:  sel.pat_color_out = direct;
            default:        sel.pat_color_out = fit_depth(sel.pat_color[0], sel.bpp8);
        endcase
    end

endmodule : bcp_color_select

`default_nettype wire

// ==== test/bcp_operand_regs_properties.sv ====
// concurrent checks on the ports of the operand register bank
`timescale 1ns/1ps
`default_nettype none
`include "bcp_regs.svh"

module bcp_operand_regs_properties (
    input wire logic                  clk_sys,
    input wire logic                  nrst,
    input wire logic                  bus_sel,
    input wire logic                  bus_wr,
    input wire logic                  bus_rd,
    input wire logic [15:0]           bus_addr,
    input wire logic [3:0]            bus_be,
    input wire logic [31:0]           bus_wdata,
    input wire logic [31:0]           bus_rdata,
    input wire logic                  bus_ack,
    input wire logic                  vector_mode,
    input wire logic                  bpp8,
    input wire bcp_pkg::bcp_pat_fmt_e pattern_format_select,
    input wire logic                  pix_req,
    input wire logic [2:0]            pix_x,
    input wire logic [2:0]            pix_y,
    input wire logic                  src_bit,
    input wire logic [15:0]           source_row_coordinate,
    input wire logic [15:0]           source_column_coordinate,
    input wire logic [15:0]           line_axial_error_term,
    input wire logic [15:0]           line_diagonal_error_term,
    input wire logic                  pix_valid,
    input wire logic [15:0]           src_pix_color,
    input wire logic [15:0]           pat_pix_color,
    input wire logic                  pat_pix_bit
);
    import bcp_pkg::*;
    logic [5:0][31:0] sh_reg;
    logic [2:0]       widx;
    logic [31:0]      rd_val;
    logic             req;
    logic [63:0]      bmp;

    // shadow of the word map so read data and pixel answers can be judged
    assign req    = bus_sel && (bus_wr || bus_rd);
    assign bmp    = {sh_reg[5], sh_reg[4]};
    assign rd_val = (widx == 3'h7) ? 32'h0 : sh_reg[widx];
    always_comb begin
        case ({bus_addr[15:2], 2'h0})
            `BCP_OFS_SRC_POS:      widx = 3'h0;
            `BCP_OFS_SRC_COLOR:    widx = 3'h1;
            `BCP_OFS_PAT_COLOR_01: widx = 3'h2;
            `BCP_OFS_PAT_COLOR_23: widx = 3'h3;
            `BCP_OFS_PAT_WORD_0:   widx = 3'h4;
            `BCP_OFS_PAT_WORD_1:   widx = 3'h5;
            default:               widx = 3'h7;
        endcase
    end
    // lanes follow the byte enables, unmapped writes are dropped
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sh_reg <= '0;
        end else if (bus_sel && bus_wr && widx != 3'h7) begin
            for (int b = 0; b < 4; b++) begin
                if (bus_be[b]) begin
                    sh_reg[widx][8*b +: 8] <= bus_wdata[8*b +: 8];
                end
            end
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    a_ack_follows_req: assert property (req |=> bus_ack)
        else $error("bus ack missing after request");
    a_ack_not_spurious: assert property (!req |=> !bus_ack)
        else $error("bus ack without request");
    a_read_word_value: assert property (
        bus_sel && bus_rd && !bus_wr |=> bus_rdata == $past(rd_val))
        else $error("read data differs from written word");
    a_pos_blt_mode: assert property (
        !$past(vector_mode) |-> {source_column_coordinate, source_row_coordinate} == $past(sh_reg[0])
        && line_axial_error_term == 16'h0 && line_diagonal_error_term == 16'h0)
        else $error("block transfer position fields wrong");
    a_err_vec_mode: assert property (
        $past(vector_mode) |-> {line_axial_error_term, line_diagonal_error_term} == $past(sh_reg[0])
        && source_row_coordinate == 16'h0 && source_column_coordinate == 16'h0)
        else $error("line error fields wrong");
    a_src_color_wide: assert property (
        pix_req && !bpp8 |=> src_pix_color == ($past(src_bit) ? $past(sh_reg[1][31:16])
        : $past(sh_reg[1][15:0])))
        else $error("source expansion colour wrong");
    a_src_color_byte: assert property (
        pix_req && bpp8 && src_bit |=> src_pix_color == {2{$past(sh_reg[1][23:16])}})
        else $error("byte source colour wrong");
    a_pat_solid_color: assert property (
        pix_req && !bpp8 && pattern_format_select == BCP_PAT_SOLID
        |=> pat_pix_color == $past(sh_reg[2][15:0]))
        else $error("solid pattern colour wrong");
    a_pat_bit_index: assert property (
        pix_req |=> pat_pix_bit == $past(bmp[{pix_y, pix_x}]))
        else $error("pattern bitmap bit wrong");
    a_pix_valid_next: assert property (pix_req |=> pix_valid)
        else $error("pixel answer missing");
endmodule : bcp_operand_regs_properties

bind bcp_operand_regs bcp_operand_regs_properties u_props (
    .clk_sys(clk_sys), .nrst(nrst), .bus_sel(bus_sel), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_addr(bus_addr), .bus_be(bus_be), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .bus_ack(bus_ack), .vector_mode(vector_mode), .bpp8(bpp8),
    .pattern_format_select(pattern_format_select), .pix_req(pix_req), .pix_x(pix_x),
    .pix_y(pix_y), .src_bit(src_bit), .source_row_coordinate(source_row_coordinate),
    .source_column_coordinate(source_column_coordinate),
    .line_axial_error_term(line_axial_error_term),
    .line_diagonal_error_term(line_diagonal_error_term), .pix_valid(pix_valid),
    .src_pix_color(src_pix_color), .pat_pix_color(pat_pix_color), .pat_pix_bit(pat_pix_bit));

`default_nettype wire

// ==== test/bcp_operand_regs_tb.sv ====
// self-checking bench for the operand register bank
`timescale 1ns/1ps
`default_nettype none
`include "bcp_regs.svh"

module bcp_operand_regs_tb;
    import bcp_pkg::*;
    logic         clk_sys, nrst, bus_sel, bus_wr, bus_rd, bus_ack, vector_mode, bpp8;
    logic         pix_req, src_bit, pix_valid, ppb;
    logic [15:0]  bus_addr, row, col, axial, diag, spc, ppc;
    logic [3:0]   bus_be;
    logic [31:0]  bus_wdata, bus_rdata;
    logic [2:0]   pix_x, pix_y;
    bcp_pat_fmt_e fmt;
    int           fail_count, cmp_count;
    logic [15:0]  ofs [6] = '{`BCP_OFS_SRC_POS, `BCP_OFS_SRC_COLOR, `BCP_OFS_PAT_COLOR_01,
                              `BCP_OFS_PAT_COLOR_23, `BCP_OFS_PAT_WORD_0, `BCP_OFS_PAT_WORD_1};
    logic [31:0]  wv [6] = '{32'h8123_FFFE, 32'h5A5A_0707, 32'h2222_1111, 32'h4444_3333,
                             32'hF0E1_D2C3, 32'h8765_4321};
    logic [5:0]   pos [5] = '{6'h00, 6'h3F, 6'h2B, 6'h16, 6'h01};
    logic [63:0]  bm;

    bcp_operand_regs u_dut (.clk_sys(clk_sys), .nrst(nrst), .bus_sel(bus_sel), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_addr(bus_addr), .bus_be(bus_be), .bus_wdata(bus_wdata),
        .bus_rdata(bus_rdata), .bus_ack(bus_ack), .vector_mode(vector_mode), .bpp8(bpp8),
        .pattern_format_select(fmt), .pix_req(pix_req), .pix_x(pix_x), .pix_y(pix_y),
        .src_bit(src_bit), .source_row_coordinate(row), .source_column_coordinate(col),
        .line_axial_error_term(axial), .line_diagonal_error_term(diag), .pix_valid(pix_valid),
        .src_pix_color(spc), .pat_pix_color(ppc), .pat_pix_bit(ppb));

    // 250 MHz system clock
    always #2 clk_sys = ~clk_sys;

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test

    // one bus cycle, then one idle cycle so the strobes never change twice in a step
    task automatic bus(input logic wr, input logic [15:0] a, input logic [3:0] be,
        input logic [31:0] d);
        bus_sel = 1'b1;
        bus_wr = wr;
        bus_rd = !wr;
        bus_addr = a;
        bus_be = be;
        bus_wdata = d;
        @(negedge clk_sys);
        check(bus_ack, 1'b1);
        bus_sel = 1'b0;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        @(negedge clk_sys);
        check(bus_ack, 1'b0);
    endtask : bus

    task automatic rd(input logic [15:0] a, input logic [31:0] exp);
        bus(1'b0, a, 4'h0, 32'h0);
        check(bus_rdata, exp);
    endtask : rd

    task automatic pix(input logic [5:0] p, input logic b);
        pix_req = 1'b1;
        pix_x = p[2:0];
        pix_y = p[5:3];
        src_bit = b;
        @(negedge clk_sys);
        check(pix_valid, 1'b1);
        pix_req = 1'b0;
        @(negedge clk_sys);
        check(pix_valid, 1'b0);
    endtask : pix

    // expected pattern colour at 16 bpp, worked out from the written words
    function automatic logic [15:0] pat_exp(input logic [5:0] p);
        logic b;
        b = bm[p];
        case (fmt)
            BCP_PAT_SOLID:  return wv[2][15:0];
            BCP_PAT_MONO:   return b ? wv[2][31:16] : wv[2][15:0];
            BCP_PAT_DITHER: return wv[2 + b][16*(p[0] ^ p[3]) +: 16];
            default:        return bm[16*p[1:0] +: 16];
        endcase
    endfunction : pat_exp

    // a hang must still end in the verdict
    initial begin
        #20000;
        fail_count++;
        $display("watchdog expired");
        end_of_test();
    end

    initial begin
        {clk_sys, nrst, bus_sel, bus_wr, bus_rd, vector_mode, bpp8, pix_req, src_bit} = '0;
        {bus_addr, bus_be, bus_wdata, pix_x, pix_y} = '0;
        fmt = BCP_PAT_SOLID;
        fail_count = 0;
        cmp_count = 0;
        bm = {wv[5], wv[4]};
        repeat (12) @(negedge clk_sys);
        nrst = 1'b1;
        foreach (ofs[i]) rd(ofs[i], 32'h0);
        foreach (ofs[i]) bus(1'b1, ofs[i], 4'hF, wv[i]);
        bus(1'b1, 16'h8118, 4'hF, 32'hFFFF_FFFF);
        rd(16'h8118, 32'h0);
        foreach (ofs[i]) rd(ofs[i], wv[i]);
        $display("test register map done");
        repeat (2) @(negedge clk_sys);
        check({col, row, axial, diag}, {wv[0], 32'h0});
        vector_mode = 1'b1;
        repeat (3) @(negedge clk_sys);
        check({col, row, axial, diag}, {32'h0, wv[0]});
        $display("test position fields done");
        bus(1'b1, `BCP_OFS_SRC_COLOR_1, 4'hC, 32'hBEEF_0000);
        pix(6'h00, 1'b0);
        check(spc, wv[1][15:0]);
        pix(6'h00, 1'b1);
        check(spc, 16'hBEEF);
        bus(1'b1, `BCP_OFS_SRC_COLOR_1, 4'hC, 32'h3C3C_0000);
        bpp8 = 1'b1;
        pix(6'h00, 1'b1);
        check(spc, 16'h3C3C);
        bpp8 = 1'b0;
        $display("test source colours done");
        for (int f = 0; f < 4; f++) begin
            fmt = bcp_pat_fmt_e'(f);
            foreach (pos[k]) begin
                pix(pos[k], 1'b0);
                check(ppc, pat_exp(pos[k]));
                check(ppb, bm[pos[k]]);
            end
        end
        bpp8 = 1'b1;
        pix(6'h2D, 1'b0);
        check(ppc, {2{bm[40 +: 8]}});
        $display("test pattern colours done");
        end_of_test();
    end
endmodule : bcp_operand_regs_tb

`default_nettype wire
